// ### inc/mitf_pkg.sv
// Purpose: Shared constants and types of the execution timing unit
// Assumes: 8-bit core, four system clocks per instruction cycle
// Notes: Opcode values are internal; the decoder maps onto them
package mitf_pkg;
  // Widths
  localparam int DATA_W = 8;
  localparam int BIDX_W = 3;
  localparam int TBLW_W = 15;
  localparam int TABLE_HIGH_BYTE_W = 7;
  localparam int CYC_W = 3;
  localparam int PH_W = 2;

  // Instruction cycle framing, four clocks each
  localparam logic [PH_W-1:0] PH_FIRST = 2'h1;
  localparam logic [PH_W-1:0] PH_LAST = 2'h3;
  localparam logic [CYC_W-1:0] CYC_ONE = 3'h1;
  localparam logic [CYC_W-1:0] CYC_TWO = 3'h2;
  localparam logic [CYC_W-1:0] CYC_NONE = 3'h0;

  // Data constants
  localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
  localparam logic [DATA_W-1:0] BYTE_ONES = 8'hff;
  localparam logic [DATA_W-1:0] BYTE_ONE = 8'h01;
  localparam logic [3:0] BCD_LIMIT = 4'h9;
  localparam logic [3:0] BCD_ADJ = 4'h6;

  // Reset values
  localparam logic [DATA_W-1:0] ACCUM_RST = 8'h00;
  localparam logic [TABLE_HIGH_BYTE_W-1:0] TABLE_HIGH_BYTE_RST = 7'h00;
  localparam logic FLAG_RST = 1'b0;

  // Operations
  typedef enum logic [5:0] {
    OP_NOP, OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_DECADJ,
    OP_AND, OP_OR, OP_XOR, OP_COMPL, OP_INC, OP_DEC,
    OP_ROR, OP_ROL, OP_RORC, OP_ROLC, OP_MOV, OP_SWAP,
    OP_BCLR, OP_BSET, OP_CLRM, OP_SETM,
    OP_JMP, OP_CALL, OP_RET, OP_RETA, OP_IRET,
    OP_SKZ, OP_SKZCOPY, OP_SKBZ, OP_SKBNZ, OP_INCSKZ, OP_DECSKZ,
    OP_TBRD_CUR, OP_TBRD_LAST,
    OP_WDCLR, OP_WDPRE_A, OP_WDPRE_B, OP_HALT
  } mitf_op_e;

  typedef enum logic {ST_IDLE, ST_EXEC} mitf_state_e;
endpackage : mitf_pkg

// ### verilog/mitf_alu.sv
// Purpose: Combinational result and flag datapath
// Assumes: Operand already selected between memory and immediate
// Notes: Flag outputs are candidates; the caller picks which to keep
`timescale 1ns/1ps
module mitf_alu
  import mitf_pkg::*;
(
  input mitf_op_e op_i,
  input logic [DATA_W-1:0] accum_i,
  input logic [DATA_W-1:0] opnd_i,
  input logic [BIDX_W-1:0] bit_idx_i,
  input logic c_i,
  input logic ac_i,
  output logic [DATA_W-1:0] res_o,
  output logic c_o,
  output logic ac_o,
  output logic ov_o,
  output logic zero_o,
  output logic bit_o
);
  logic [DATA_W-1:0] b_s;
  logic [DATA_W-1:0] bmask;
  logic [DATA_W:0] sum9;
  logic [4:0] nib;
  logic [4:0] lo_s;
  logic [4:0] hi_t;
  logic [4:0] hi_s;
  logic cin;

  // One adder serves add and subtract; subtract is add of inverse
  always_comb begin
    bmask = BYTE_ONE << bit_idx_i;
    b_s = opnd_i;
    cin = 1'b0;
    nib = 5'h00;
    sum9 = 9'h000;
    lo_s = 5'h00;
    hi_t = 5'h00;
    hi_s = 5'h00;
    res_o = opnd_i;
    c_o = c_i;
    ac_o = ac_i;
    ov_o = 1'b0;
    case (op_i)
      OP_ADD, OP_ADC, OP_SUB, OP_SBC: begin
        if (op_i == OP_SUB || op_i == OP_SBC) begin
          b_s = ~opnd_i;
        end
        if (op_i == OP_SUB) begin
          cin = 1'b1;
        end else if (op_i != OP_ADD) begin
          cin = c_i;
        end
        nib = {1'b0, accum_i[3:0]} + {1'b0, b_s[3:0]} + {4'h0, cin};
        sum9 = {1'b0, accum_i} + {1'b0, b_s} + {8'h00, cin};
        res_o = sum9[DATA_W-1:0];
        c_o = sum9[DATA_W];
        ac_o = nib[4];
        ov_o = (accum_i[7] == b_s[7]) && (sum9[7] != accum_i[7]);
      end
      // Carry only ever gets set here, never cleared
      OP_DECADJ: begin
        lo_s = {1'b0, accum_i[3:0]};
        if (accum_i[3:0] > BCD_LIMIT || ac_i) begin
          lo_s = lo_s + {1'b0, BCD_ADJ};
        end
        hi_t = {1'b0, accum_i[7:4]} + {4'h0, lo_s[4]};
        hi_s = hi_t;
        if (hi_t > {1'b0, BCD_LIMIT} || c_i) begin
          hi_s = hi_t + {1'b0, BCD_ADJ};
        end
        res_o = {hi_s[3:0], lo_s[3:0]};
        c_o = c_i | hi_s[4];
      end
      OP_AND: res_o = accum_i & opnd_i;
      OP_OR: res_o = accum_i | opnd_i;
      OP_XOR: res_o = accum_i ^ opnd_i;
      OP_COMPL: res_o = ~opnd_i;
      OP_INC, OP_INCSKZ: res_o = opnd_i + BYTE_ONE;
      OP_DEC, OP_DECSKZ: res_o = opnd_i - BYTE_ONE;
      OP_ROR: res_o = {opnd_i[0], opnd_i[7:1]};
      OP_ROL: res_o = {opnd_i[6:0], opnd_i[7]};
      OP_RORC: begin
        res_o = {c_i, opnd_i[7:1]};
        c_o = opnd_i[0];
      end
      OP_ROLC: begin
        res_o = {opnd_i[6:0], c_i};
        c_o = opnd_i[7];
      end
      OP_SWAP: res_o = {opnd_i[3:0], opnd_i[7:4]};
      OP_BCLR: res_o = opnd_i & ~bmask;
      OP_BSET: res_o = opnd_i | bmask;
      OP_CLRM: res_o = BYTE_ZERO;
      OP_SETM: res_o = BYTE_ONES;
      default: res_o = opnd_i;
    endcase
  end

  // Zero and bit test views
  assign zero_o = (res_o == BYTE_ZERO);
  assign bit_o = opnd_i[bit_idx_i];
endmodule : mitf_alu

// ### verilog/mitf_exec.sv
// Purpose: Instruction execution timing and status flag unit
// Assumes: One request per start_i pulse while not busy
// Notes: All results are registered at the edge that takes the request
`timescale 1ns/1ps
module mitf_exec
  import mitf_pkg::*;
(
  input logic clock_i,
  input logic srst_i,
  input logic start_i,
  input mitf_op_e op_i,
  input logic src_imm_i,
  input logic dst_mem_i,
  input logic dst_prog_counter_low_i,
  input logic [DATA_W-1:0] imm_i,
  input logic [BIDX_W-1:0] bit_idx_i,
  input logic [DATA_W-1:0] mem_rdata_i,
  input logic [TBLW_W-1:0] table_word_i,
  input logic wake_i,
  output logic busy_o,
  output logic done_o,
  output logic [CYC_W-1:0] icycles_o,
  output logic [DATA_W-1:0] accumulator_reg_o,
  output logic mem_we_o,
  output logic [DATA_W-1:0] mem_wdata_o,
  output logic [TABLE_HIGH_BYTE_W-1:0] table_high_byte_o,
  output logic table_last_page_o,
  output logic skip_o,
  output logic zero_flag_o,
  output logic carry_flag_o,
  output logic aux_carry_flag_o,
  output logic overflow_flag_o,
  output logic timeout_flag_o,
  output logic powerdown_flag_o,
  output logic wdt_clear_o,
  output logic powerdown_o
);
  mitf_state_e state_r, state_nxt;
  logic [PH_W-1:0] phase_r, phase_nxt;
  logic [CYC_W-1:0] left_r, left_nxt;
  logic [CYC_W-1:0] icyc_r, icyc_nxt;
  logic busy_r, busy_nxt;
  logic done_r, done_nxt;
  logic [DATA_W-1:0] accum_r, accum_nxt;
  logic [DATA_W-1:0] wdata_r, wdata_nxt;
  logic we_r, we_nxt;
  logic [TABLE_HIGH_BYTE_W-1:0] table_high_byte_r, table_high_byte_nxt;
  logic tlast_r, tlast_nxt;
  logic skip_r, skip_nxt;
  logic z_r, z_nxt, c_r, c_nxt, ac_r, ac_nxt, ov_r, ov_nxt;
  logic to_r, to_nxt, pdf_r, pdf_nxt;
  logic wclr_r, wclr_nxt, pwr_r, pwr_nxt;
  logic pre_a_r, pre_a_nxt, pre_b_r, pre_b_nxt;
  logic accept_c, wr_mem_c, wr_acc_c, pcl_hit_c;
  logic upd_arith_c, upd_z_c, upd_c_c, base2_c, skip_c;
  logic [CYC_W-1:0] total_c;
  logic [DATA_W-1:0] opnd_c, res_c;
  logic alu_c, alu_ac, alu_ov, alu_zero, alu_bit;

  // A request is refused while busy or powered down
  assign accept_c = start_i && (state_r == ST_IDLE) && !pwr_r;

  assign opnd_c = (src_imm_i || op_i == OP_RETA) ? imm_i : mem_rdata_i;

  mitf_alu u_alu (
    .op_i(op_i),
    .accum_i(accum_r),
    .opnd_i(opnd_c),
    .bit_idx_i(bit_idx_i),
    .c_i(c_r),
    .ac_i(ac_r),
    .res_o(res_c),
    .c_o(alu_c),
    .ac_o(alu_ac),
    .ov_o(alu_ov),
    .zero_o(alu_zero),
    .bit_o(alu_bit)
  );

  // Decode of target, flag class, base length and skip outcome
  always_comb begin
    wr_mem_c = 1'b0;
    wr_acc_c = 1'b0;
    upd_arith_c = 1'b0;
    upd_z_c = 1'b0;
    upd_c_c = 1'b0;
    base2_c = 1'b0;
    skip_c = 1'b0;
    case (op_i)
      OP_ADD, OP_ADC, OP_SUB, OP_SBC: begin
        upd_arith_c = 1'b1;
        wr_mem_c = dst_mem_i;
        wr_acc_c = !dst_mem_i;
      end
      OP_DECADJ: begin
        wr_mem_c = 1'b1;
        upd_c_c = 1'b1;
      end
      OP_AND, OP_OR, OP_XOR, OP_COMPL, OP_INC, OP_DEC: begin
        upd_z_c = 1'b1;
        wr_mem_c = dst_mem_i;
        wr_acc_c = !dst_mem_i;
      end
      OP_ROR, OP_ROL, OP_SWAP, OP_MOV: begin
        wr_mem_c = dst_mem_i;
        wr_acc_c = !dst_mem_i;
      end
      OP_RORC, OP_ROLC: begin
        upd_c_c = 1'b1;
        wr_mem_c = dst_mem_i;
        wr_acc_c = !dst_mem_i;
      end
      OP_BCLR, OP_BSET, OP_CLRM, OP_SETM: wr_mem_c = 1'b1;
      OP_JMP, OP_CALL, OP_RET, OP_IRET: base2_c = 1'b1;
      OP_RETA: begin
        base2_c = 1'b1;
        wr_acc_c = 1'b1;
      end
      OP_SKZ: skip_c = alu_zero;
      OP_SKBZ: skip_c = !alu_bit;
      OP_SKBNZ: skip_c = alu_bit;
      OP_SKZCOPY: begin
        wr_acc_c = 1'b1;
        skip_c = alu_zero;
      end
      OP_INCSKZ, OP_DECSKZ: begin
        wr_mem_c = dst_mem_i;
        wr_acc_c = !dst_mem_i;
        skip_c = alu_zero;
      end
      OP_TBRD_CUR, OP_TBRD_LAST: begin
        base2_c = 1'b1;
        wr_mem_c = 1'b1;
      end
      default: wr_mem_c = 1'b0;
    endcase
  end

  assign pcl_hit_c = wr_mem_c && dst_prog_counter_low_i;
  assign total_c = (base2_c ? CYC_TWO : CYC_ONE) + {2'b00, pcl_hit_c} +
                   {2'b00, skip_c};

  // Cycle framing; the taking edge counts as phase zero
  always_comb begin
    state_nxt = state_r;
    phase_nxt = phase_r;
    left_nxt = left_r;
    icyc_nxt = icyc_r;
    done_nxt = 1'b0;
    if (accept_c) begin
      state_nxt = ST_EXEC;
      phase_nxt = PH_FIRST;
      left_nxt = total_c - CYC_ONE;
      icyc_nxt = total_c;
    end else if (state_r == ST_EXEC) begin
      phase_nxt = phase_r + PH_FIRST;
      if (phase_r == PH_LAST) begin
        if (left_r == CYC_NONE) begin
          state_nxt = ST_IDLE;
          done_nxt = 1'b1;
        end else begin
          left_nxt = left_r - CYC_ONE;
        end
      end
    end
    busy_nxt = (state_nxt == ST_EXEC);
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      state_r <= ST_IDLE;
      phase_r <= '0;
      left_r <= CYC_NONE;
      icyc_r <= CYC_NONE;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      phase_r <= phase_nxt;
      left_r <= left_nxt;
      icyc_r <= icyc_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
    end
  end

  // Results, flags and watchdog bookkeeping
  always_comb begin
    accum_nxt = accum_r;
    wdata_nxt = wdata_r;
    we_nxt = 1'b0;
    table_high_byte_nxt = table_high_byte_r;
    tlast_nxt = tlast_r;
    skip_nxt = skip_r;
    z_nxt = z_r;
    c_nxt = c_r;
    ac_nxt = ac_r;
    ov_nxt = ov_r;
    to_nxt = to_r;
    pdf_nxt = pdf_r;
    wclr_nxt = 1'b0;
    pwr_nxt = pwr_r && !wake_i;
    pre_a_nxt = pre_a_r;
    pre_b_nxt = pre_b_r;
    if (accept_c) begin
      skip_nxt = skip_c;
      if (wr_acc_c) begin
        accum_nxt = res_c;
      end
      if (wr_mem_c) begin
        we_nxt = 1'b1;
        wdata_nxt = (op_i == OP_MOV) ? accum_r : res_c;
      end
      if (op_i == OP_TBRD_CUR || op_i == OP_TBRD_LAST) begin
        wdata_nxt = table_word_i[DATA_W-1:0];
        table_high_byte_nxt = table_word_i[TBLW_W-1:DATA_W];
        tlast_nxt = (op_i == OP_TBRD_LAST);
      end
      if (upd_arith_c) begin
        z_nxt = alu_zero;
        c_nxt = alu_c;
        ac_nxt = alu_ac;
        ov_nxt = alu_ov;
      end
      if (upd_z_c) begin
        z_nxt = alu_zero;
      end
      if (upd_c_c) begin
        c_nxt = alu_c;
      end
      case (op_i)
        OP_WDCLR: begin
          to_nxt = 1'b0;
          pdf_nxt = 1'b0;
          wclr_nxt = 1'b1;
          pre_a_nxt = 1'b0;
          pre_b_nxt = 1'b0;
        end
        OP_WDPRE_A, OP_WDPRE_B: begin
          if ((op_i == OP_WDPRE_A) ? pre_b_r : pre_a_r) begin
            to_nxt = 1'b1;
            pdf_nxt = 1'b0;
            wclr_nxt = 1'b1;
            pre_a_nxt = 1'b0;
            pre_b_nxt = 1'b0;
          end else if (op_i == OP_WDPRE_A) begin
            pre_a_nxt = 1'b1;
          end else begin
            pre_b_nxt = 1'b1;
          end
        end
        OP_HALT: begin
          to_nxt = 1'b0;
          pdf_nxt = 1'b1;
          pwr_nxt = 1'b1;
        end
        default: pwr_nxt = pwr_r && !wake_i;
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      accum_r <= ACCUM_RST;
      wdata_r <= BYTE_ZERO;
      we_r <= 1'b0;
      table_high_byte_r <= TABLE_HIGH_BYTE_RST;
      tlast_r <= 1'b0;
      skip_r <= 1'b0;
      {z_r, c_r, ac_r, ov_r} <= {4{FLAG_RST}};
      {to_r, pdf_r} <= {2{FLAG_RST}};
      wclr_r <= 1'b0;
      pwr_r <= 1'b0;
      pre_a_r <= 1'b0;
      pre_b_r <= 1'b0;
    end else begin
      accum_r <= accum_nxt;
      wdata_r <= wdata_nxt;
      we_r <= we_nxt;
      table_high_byte_r <= table_high_byte_nxt;
      tlast_r <= tlast_nxt;
      skip_r <= skip_nxt;
      {z_r, c_r, ac_r, ov_r} <= {z_nxt, c_nxt, ac_nxt, ov_nxt};
      {to_r, pdf_r} <= {to_nxt, pdf_nxt};
      wclr_r <= wclr_nxt;
      pwr_r <= pwr_nxt;
      pre_a_r <= pre_a_nxt;
      pre_b_r <= pre_b_nxt;
    end
  end

  // Registered outputs
  assign busy_o = busy_r;
  assign done_o = done_r;
  assign icycles_o = icyc_r;
  assign accumulator_reg_o = accum_r;
  assign mem_we_o = we_r;
  assign mem_wdata_o = wdata_r;
  assign table_high_byte_o = table_high_byte_r;
  assign table_last_page_o = tlast_r;
  assign skip_o = skip_r;
  assign zero_flag_o = z_r;
  assign carry_flag_o = c_r;
  assign aux_carry_flag_o = ac_r;
  assign overflow_flag_o = ov_r;
  assign timeout_flag_o = to_r;
  assign powerdown_flag_o = pdf_r;
  assign wdt_clear_o = wclr_r;
  assign powerdown_o = pwr_r;

  // Checks on timing and flag effects
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);

  sequence s_take_one;
    accept_c && !base2_c && !pcl_hit_c && !skip_c;
  endsequence
  sequence s_take_arith;
    accept_c && upd_arith_c && !pcl_hit_c;
  endsequence
  sequence s_frame_one;
    busy_o [*3] ##1 done_o;
  endsequence

  AST_ONE_CYCLE: assert property (s_take_one |=> s_frame_one)
    else $error("single cycle instruction not four clocks");
  AST_ARITH_TIME: assert property (s_take_arith |-> ##4 done_o)
    else $error("arithmetic not done in one cycle");
  AST_PCL_EXTRA: assert property (
    accept_c && pcl_hit_c && !base2_c && !skip_c |-> ##8 done_o)
    else $error("program counter low write lacks extra cycle");
  AST_BRANCH_TWO: assert property (
    accept_c && base2_c && !pcl_hit_c |-> ##4 !done_o ##4 done_o)
    else $error("two cycle instruction wrong length");
  AST_SKIP_BOTH: assert property (
    accept_c && skip_c && pcl_hit_c |=> icycles_o == 3'h3 ##11 done_o)
    else $error("counted skip lacks both extra cycles");
  AST_LOGIC_FLAGS: assert property (
    accept_c && upd_z_c
    |=> $stable({carry_flag_o, aux_carry_flag_o, overflow_flag_o}))
    else $error("logic op changed a flag other than zero");
  AST_MOVE_FLAGS: assert property (
    accept_c && op_i == OP_MOV
    |=> $stable({zero_flag_o, carry_flag_o, overflow_flag_o}))
    else $error("move changed a flag");
  AST_COMPL_ACC: assert property (
    accept_c && op_i == OP_COMPL && !dst_mem_i
    |=> !mem_we_o && accumulator_reg_o == ~$past(opnd_c))
    else $error("complement to accumulator wrong");
  AST_PRECLEAR_HIT: assert property (
    accept_c && op_i == OP_WDPRE_A && pre_b_r
    |=> wdt_clear_o && timeout_flag_o && !powerdown_flag_o)
    else $error("effective pre-clear flags wrong");
  AST_PRECLEAR_MISS: assert property (
    accept_c && op_i == OP_WDPRE_B && !pre_a_r
    |=> !wdt_clear_o && $stable(timeout_flag_o) &&
    $stable(powerdown_flag_o))
    else $error("ineffective pre-clear touched flags");
  AST_HALT: assert property (
    accept_c && op_i == OP_HALT
    |=> powerdown_o && powerdown_flag_o && !timeout_flag_o)
    else $error("halt did not power down");
endmodule : mitf_exec

// ### verif/mitf_mem_model.sv
// Purpose: Data and program memory stand-in for the execution unit
// Assumes: One data byte and one program word serve each request
// Notes: A write lands at the edge where mem_we_i is high
`timescale 1ns/1ps
module mitf_mem_model
  import mitf_pkg::*;
(
  input wire logic clock_i,
  input wire logic load_i,
  input wire logic [DATA_W-1:0] load_byte_i,
  input wire logic [TBLW_W-1:0] load_word_i,
  input wire logic mem_we_i,
  input wire logic [DATA_W-1:0] mem_wdata_i,
  output logic [DATA_W-1:0] mem_rdata_o,
  output logic [TBLW_W-1:0] table_word_o
);
  // Cell and word; the bench preload wins over a write
  always @(posedge clock_i) begin
    if (load_i) begin
      mem_rdata_o <= load_byte_i;
      table_word_o <= load_word_i;
    end else if (mem_we_i) begin
      mem_rdata_o <= mem_wdata_i;
    end
  end
endmodule : mitf_mem_model

// ### verif/tb.sv
// Purpose: Self-checking bench for the execution timing unit
// Assumes: Inputs change at the falling edge only
// Notes: Flag expectations are tracked across rows, so row order matters
`timescale 1ns/1ps
module tb;
  import mitf_pkg::*;
  typedef struct packed {
    mitf_op_e op;
    logic [3:0] ctl; // write, immediate, memory target, low pc target
    logic [7:0] opd;
    logic [2:0] bi;
    logic [7:0] pre;
    logic [7:0] res;
    logic [2:0] cyc;
    logic skp;
    logic [7:0] fl; // Mask then value, zero/carry/aux/overflow
  } mitf_row_s;
  logic clock_i = 1'b0;
  logic srst_i = 1'b1;
  logic start_i = 1'b0;
  mitf_op_e op_i = OP_NOP;
  logic src_imm_i = 1'b0;
  logic dst_mem_i = 1'b0;
  logic pc_low_sel = 1'b0;
  logic [7:0] imm_i = 8'h00;
  logic [2:0] bit_idx_i = 3'h0;
  logic wake_i = 1'b0;
  logic load_i = 1'b0;
  logic [7:0] load_byte = 8'h00;
  logic [14:0] load_word = 15'h0000;
  logic [7:0] mem_rdata;
  logic [14:0] table_word;
  logic busy_o, done_o, mem_we_o, skip_o, wdt_clear_o, powerdown_o;
  logic table_last_page_o, zero_flag_o, carry_flag_o, aux_carry_flag_o;
  logic overflow_flag_o, timeout_flag_o, powerdown_flag_o;
  logic [2:0] icycles_o;
  logic [7:0] accumulator_reg_o, mem_wdata_o;
  logic [6:0] table_high_byte_o;
  logic [3:0] flg, ef;
  logic [2:0] wd_v;
  int error_cnt = 0;
  int n_tests = 0;
  mitf_row_s r;
  mitf_row_s rows [37] = '{
    '{OP_ADD,4'h4,8'h01,3'h0,8'h7f,8'h80,3'h1,1'h0,8'hf3},
    '{OP_ADC,4'ha,8'h01,3'h0,8'hff,8'h00,3'h1,1'h0,8'hfe},
    '{OP_SUB,4'h4,8'h12,3'h0,8'h35,8'h23,3'h1,1'h0,8'hf6},
    '{OP_SBC,4'hb,8'h01,3'h0,8'h80,8'h7f,3'h2,1'h0,8'hf5},
    '{OP_DECADJ,4'ha,8'h00,3'h0,8'h12,8'h72,3'h1,1'h0,8'h44},
    '{OP_AND,4'h4,8'h0f,3'h0,8'hf0,8'h00,3'h1,1'h0,8'h88},
    '{OP_OR,4'ha,8'h02,3'h0,8'h01,8'h03,3'h1,1'h0,8'h80},
    '{OP_XOR,4'h4,8'h55,3'h0,8'h55,8'h00,3'h1,1'h0,8'h88},
    '{OP_COMPL,4'h0,8'hff,3'h0,8'h33,8'h00,3'h1,1'h0,8'h88},
    '{OP_COMPL,4'ha,8'h0f,3'h0,8'h33,8'hf0,3'h1,1'h0,8'h80},
    '{OP_INC,4'h0,8'hff,3'h0,8'h33,8'h00,3'h1,1'h0,8'h88},
    '{OP_DEC,4'ha,8'h01,3'h0,8'h33,8'h00,3'h1,1'h0,8'h88},
    '{OP_ROR,4'h0,8'h01,3'h0,8'h33,8'h80,3'h1,1'h0,8'h00},
    '{OP_ROL,4'ha,8'h81,3'h0,8'h33,8'h03,3'h1,1'h0,8'h00},
    '{OP_RORC,4'h0,8'h02,3'h0,8'h33,8'h81,3'h1,1'h0,8'h40},
    '{OP_ROLC,4'ha,8'h80,3'h0,8'h33,8'h00,3'h1,1'h0,8'h44},
    '{OP_MOV,4'ha,8'h00,3'h0,8'h5a,8'h5a,3'h1,1'h0,8'h00},
    '{OP_SWAP,4'h0,8'h12,3'h0,8'h33,8'h21,3'h1,1'h0,8'h00},
    '{OP_SWAP,4'ha,8'hab,3'h0,8'h33,8'hba,3'h1,1'h0,8'h00},
    '{OP_BSET,4'ha,8'h00,3'h7,8'h33,8'h80,3'h1,1'h0,8'h00},
    '{OP_BCLR,4'ha,8'hff,3'h0,8'h33,8'hfe,3'h1,1'h0,8'h00},
    '{OP_CLRM,4'ha,8'h5a,3'h0,8'h33,8'h00,3'h1,1'h0,8'h00},
    '{OP_SETM,4'ha,8'h5a,3'h0,8'h33,8'hff,3'h1,1'h0,8'h00},
    '{OP_JMP,4'h0,8'h00,3'h0,8'h11,8'h11,3'h2,1'h0,8'h00},
    '{OP_CALL,4'h0,8'h00,3'h0,8'h11,8'h11,3'h2,1'h0,8'h00},
    '{OP_RET,4'h0,8'h00,3'h0,8'h11,8'h11,3'h2,1'h0,8'h00},
    '{OP_IRET,4'h0,8'h00,3'h0,8'h11,8'h11,3'h2,1'h0,8'h00},
    '{OP_RETA,4'h4,8'h42,3'h0,8'h11,8'h42,3'h2,1'h0,8'h00},
    '{OP_NOP,4'h0,8'h00,3'h0,8'h11,8'h11,3'h1,1'h0,8'h00},
    '{OP_SKZ,4'h0,8'h00,3'h0,8'h11,8'h11,3'h2,1'h1,8'h00},
    '{OP_SKZ,4'h0,8'h01,3'h0,8'h11,8'h11,3'h1,1'h0,8'h00},
    '{OP_SKZCOPY,4'h0,8'h07,3'h0,8'h11,8'h07,3'h1,1'h0,8'h00},
    '{OP_SKBZ,4'h0,8'hfe,3'h0,8'h11,8'h11,3'h2,1'h1,8'h00},
    '{OP_SKBNZ,4'h0,8'hfe,3'h0,8'h11,8'h11,3'h1,1'h0,8'h00},
    '{OP_INCSKZ,4'hb,8'hff,3'h0,8'h11,8'h00,3'h3,1'h1,8'h00},
    '{OP_DECSKZ,4'ha,8'h05,3'h0,8'h11,8'h04,3'h1,1'h0,8'h00},
    '{OP_DECSKZ,4'h0,8'h01,3'h0,8'h11,8'h00,3'h2,1'h1,8'h00}
  };
  mitf_op_e wops [5] = '{OP_WDPRE_A, OP_WDPRE_B, OP_WDPRE_B, OP_WDPRE_A,
    OP_WDCLR};
  logic [2:0] wexp [5] = '{3'h1, 3'h6, 3'h2, 3'h6, 3'h4};

  // Packed views of the flag outputs
  assign flg = {zero_flag_o, carry_flag_o, aux_carry_flag_o, overflow_flag_o};
  assign wd_v = {wdt_clear_o, timeout_flag_o, powerdown_flag_o};

  always #10 clock_i = ~clock_i;

  mitf_exec i_mitf_exec (.clock_i(clock_i), .srst_i(srst_i),
    .start_i(start_i), .op_i(op_i), .src_imm_i(src_imm_i),
    .dst_mem_i(dst_mem_i), .dst_prog_counter_low_i(pc_low_sel),
    .imm_i(imm_i), .bit_idx_i(bit_idx_i), .mem_rdata_i(mem_rdata),
    .table_word_i(table_word), .wake_i(wake_i), .busy_o(busy_o),
    .done_o(done_o), .icycles_o(icycles_o),
    .accumulator_reg_o(accumulator_reg_o), .mem_we_o(mem_we_o),
    .mem_wdata_o(mem_wdata_o), .table_high_byte_o(table_high_byte_o),
    .table_last_page_o(table_last_page_o), .skip_o(skip_o),
    .zero_flag_o(zero_flag_o), .carry_flag_o(carry_flag_o),
    .aux_carry_flag_o(aux_carry_flag_o), .overflow_flag_o(overflow_flag_o),
    .timeout_flag_o(timeout_flag_o), .powerdown_flag_o(powerdown_flag_o),
    .wdt_clear_o(wdt_clear_o), .powerdown_o(powerdown_o));

  mitf_mem_model i_mitf_mem_model (.clock_i(clock_i), .load_i(load_i),
    .load_byte_i(load_byte), .load_word_i(load_word), .mem_we_i(mem_we_o),
    .mem_wdata_i(mem_wdata_o), .mem_rdata_o(mem_rdata),
    .table_word_o(table_word));

  task automatic report_and_stop;
    $display("comparisons=%0d mismatches=%0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_val

  // Preload memory, then one request; returns in cycle 1
  task automatic issue(input mitf_op_e op, input logic [3:0] ctl,
    input logic [7:0] opd, input logic [2:0] bi);
    @(negedge clock_i);
    load_i = 1'b1;
    load_byte = opd;
    @(negedge clock_i);
    load_i = 1'b0;
    start_i = 1'b1;
    op_i = op;
    {src_imm_i, dst_mem_i, pc_low_sel} = ctl[2:0];
    imm_i = opd;
    bit_idx_i = bi;
    @(negedge clock_i);
    start_i = 1'b0;
  endtask : issue

  // Bounded wait for the frame end; k0 is the current cycle index
  task automatic wait_done(input int n, input int k0);
    int k;
    k = k0;
    while (done_o !== 1'b1 && k < 64) begin
      @(negedge clock_i);
      k++;
    end
    if (k >= 64) begin
      error_cnt++;
      report_and_stop();
    end
    chk_val(16'(k), 16'(4 * n));
    chk_val(busy_o, 1'b0);
  endtask : wait_done

  initial begin
    repeat (12) @(negedge clock_i);
    srst_i = 1'b0;
    @(negedge clock_i);
    chk_val({busy_o, accumulator_reg_o, flg, wd_v}, 16'h0000);
    $display("reset values done");
    ef = 4'h0;
    for (int i = 0; i < 37; i++) begin
      r = rows[i];
      issue(OP_MOV, 4'h4, r.pre, 3'h0);
      wait_done(1, 1);
      issue(r.op, r.ctl, r.opd, r.bi);
      ef = (ef & ~r.fl[7:4]) | (r.fl[3:0] & r.fl[7:4]);
      chk_val({busy_o, mem_we_o, icycles_o, skip_o}, {2'b11, r.ctl[3] ? r.cyc
        : {r.cyc[2:0]}, r.skp} ^ {1'b0, ~r.ctl[3], 4'h0});
      if (r.ctl[3]) begin
        chk_val(mem_wdata_o, r.res);
      end
      chk_val(accumulator_reg_o, r.ctl[3] ? r.pre : r.res);
      chk_val(flg, ef);
      wait_done(r.cyc, 1);
      chk_val(mem_rdata, r.ctl[3] ? r.res : r.opd);
      $display("row %0d done", i);
    end
    for (int j = 0; j < 2; j++) begin
      load_word = j ? 15'h0123 : 15'h7abc;
      issue(j ? OP_TBRD_LAST : OP_TBRD_CUR, 4'ha, 8'h00, 3'h0);
      chk_val({mem_we_o, mem_wdata_o}, j ? 9'h123 : 9'h1bc);
      chk_val({table_last_page_o, table_high_byte_o}, j ? 8'h81 : 8'h7a);
      wait_done(2, 1);
      $display("table read %0d done", j);
    end
    issue(OP_ADD, 4'h4, 8'h01, 3'h0);
    @(negedge clock_i);
    start_i = 1'b1;
    op_i = OP_MOV;
    imm_i = 8'h99;
    @(negedge clock_i);
    start_i = 1'b0;
    wait_done(1, 3);
    chk_val({accumulator_reg_o, flg}, 12'h010);
    $display("busy refusal done");
    issue(OP_HALT, 4'h0, 8'h00, 3'h0);
    chk_val({powerdown_o, wd_v[1:0]}, 3'h5);
    wait_done(1, 1);
    issue(OP_MOV, 4'h4, 8'h77, 3'h0);
    chk_val({busy_o, accumulator_reg_o}, 9'h001);
    wake_i = 1'b1;
    @(negedge clock_i);
    wake_i = 1'b0;
    @(negedge clock_i);
    chk_val(powerdown_o, 1'b0);
    for (int j = 0; j < 5; j++) begin
      issue(wops[j], 4'h0, 8'h00, 3'h0);
      chk_val(wd_v, wexp[j]);
      wait_done(1, 1);
    end
    $display("watchdog sequence done");
    // Reset in mid frame
    issue(OP_ADD, 4'h4, 8'h05, 3'h0);
    srst_i = 1'b1;
    @(negedge clock_i);
    srst_i = 1'b0;
    @(negedge clock_i);
    chk_val({busy_o, accumulator_reg_o, flg}, 13'h0000);
    $display("mid reset done");
    report_and_stop();
  end
endmodule : tb
